/* File: logic/acd_decode.sv */
// splits a port write into control and command fields
`timescale 1ns/1ps
`include "acd_map.svh"
module acd_decode
  import acd_pkg::*;
(
  input  wire logic [8:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  acd_cmd_if.dec          cmd
);
  logic hit;
  assign hit = wr_in && (addr_in == `ACD_PORT_OFFSET);
  assign cmd.ctl  = wdata_in[`ACD_CTL_MSB:`ACD_CTL_LSB];
  assign cmd.data = wdata_in[`ACD_COM_MSB:`ACD_COM_LSB];
  assign cmd.code = wdata_in[`ACD_COM_MSB:`ACD_COM_LSB];
  assign cmd.exec = hit && (cmd.ctl == `ACD_CTL_EXEC);
  assign cmd.load = hit && (cmd.ctl != `ACD_CTL_EXEC);
  assign cmd.chip_rst = cmd.exec && (cmd.code == `ACD_CMD_CHIP_RST);
endmodule

/* File: logic/acd_hidden.sv */
// bank of five hidden registers loaded through the command port
`timescale 1ns/1ps
`include "acd_map.svh"
module acd_hidden
  import acd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  acd_cmd_if.use_side     cmd,
  output acd_field_t      hid_out [`ACD_NUM_HIDDEN]
);
  localparam acd_ctl_t SEL [`ACD_NUM_HIDDEN] =
    '{`ACD_CTL_AUXA, `ACD_CTL_AUXB, `ACD_CTL_PPR, `ACD_CTL_AUXE, `ACD_CTL_ICR};
  localparam acd_field_t RST [`ACD_NUM_HIDDEN] =
    '{`ACD_HID_RST, `ACD_HID_RST, `ACD_HID_RST, `ACD_HID_RST, `ACD_ICR_RST};
  // poll response register keeps its contents over a chip reset
  localparam logic [`ACD_NUM_HIDDEN-1:0] CLR_ON_CMD = 5'b1_1011;

  genvar i;
  generate
    for (i = 0; i < `ACD_NUM_HIDDEN; i++)
    begin : g_reg
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          hid_out[i] <= RST[i];
        else if (cmd.chip_rst && CLR_ON_CMD[i])
          hid_out[i] <= RST[i];
        else if (cmd.load && cmd.ctl == SEL[i])
          hid_out[i] <= cmd.data;
      end
    end
  endgenerate
endmodule

/* File: logic/acd_top.sv */
// auxiliary command port: executes aux commands and loads hidden registers
// Operation
// - port decoded at offset 11B, write only; reads return zero
// - byte splits into control code 7..5 and command code 4..0
// - zero control code executes the selected auxiliary command
// - nonzero control code loads command bits into the selected hidden register
// - five hidden registers: aux A, aux B, poll response, aux E, counter
// - code 07 marks held secondary invalid, 0F marks it valid
// - code 01 clears local parallel poll flag, 09 sets it
// - 11 takes control async pulse, 12 synchronously, 10 goes standby
// - 1A takes control synchronously after end of current transfer
// - 1B listens continuously, 1C local unlisten, 13 plain listen
// - power-on command raises local power-on forcing functions idle
// - power-on command while power-on already held drops the message
// - chip reset acts as external reset and clears system controller bit
// - chip reset clears serial poll mode, end bit, aux A, B, E
// - chip reset clears parallel poll flag and system control request
// - chip reset sets counter register to eight
// - chip reset clears both transceiver mode bits
// - after chip reset functions stay idle until power-on command
// - acceptor stays stalled while a secondary is held until 07 or 0F
// - code 03 finishes a handshake stopped by a holdoff
`timescale 1ns/1ps
`include "acd_map.svh"
module acd_top
  import acd_pkg::*;
(
  input  wire logic       REF_CLK_IN,
  input  wire logic       SYS_RST_IN,
  input  wire logic [8:0] BUS_ADDR_IN,
  input  wire logic [7:0] BUS_WDATA_IN,
  input  wire logic       BUS_WR_IN,
  input  wire logic       BUS_RD_IN,
  input  wire logic       SEC_HELD_IN,
  output logic      [7:0] BUS_RDATA_OUT,
  output logic            PON_OUT,
  output logic            CHIP_RST_OUT,
  output logic            ACC_STALL_OUT,
  output logic            SEC_VALID_OUT,
  output logic            SEC_INVALID_OUT,
  output logic            FINISH_HS_OUT,
  output logic            PP_FLAG_OUT,
  output logic            TAKE_ASYNC_OUT,
  output logic            TAKE_SYNC_OUT,
  output logic            TAKE_ON_END_OUT,
  output logic            STANDBY_OUT,
  output logic            LISTEN_OUT,
  output logic            LISTEN_CONT_OUT,
  output logic            UNLISTEN_OUT,
  output logic      [4:0] AUX_A_OUT,
  output logic      [4:0] AUX_B_OUT,
  output logic      [4:0] POLL_RESP_OUT,
  output logic      [4:0] AUX_E_OUT,
  output logic      [4:0] COUNTER_OUT
);
  acd_cmd_if cmd ();
  acd_field_t hid [`ACD_NUM_HIDDEN];
  acd_pon_state_t pon_state;
  acd_pon_state_t next_pon_state;

  acd_decode u_decode (
    .addr_in  (BUS_ADDR_IN),
    .wdata_in (BUS_WDATA_IN),
    .wr_in    (BUS_WR_IN),
    .cmd      (cmd.dec)
  );

  acd_hidden u_hidden (
    .clk     (REF_CLK_IN),
    .rst     (SYS_RST_IN),
    .cmd     (cmd.use_side),
    .hid_out (hid)
  );

  // hidden bank already registers its outputs
  assign AUX_A_OUT     = hid[0];
  assign AUX_B_OUT     = hid[1];
  assign POLL_RESP_OUT = hid[2];
  assign AUX_E_OUT     = hid[3];
  assign COUNTER_OUT   = hid[4];

  logic is_pon;
  assign is_pon = cmd.exec && cmd.code == `ACD_CMD_PON;

  // port is write only: no command state leaks out on a read
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      BUS_RDATA_OUT <= 8'h00;
    else
      BUS_RDATA_OUT <= 8'h00;
  end

  always_comb
  begin
    next_pon_state = pon_state;
    case (pon_state)
      PON_RUN:
        if (cmd.chip_rst)
          next_pon_state = PON_HELD;
        else if (is_pon)
          next_pon_state = PON_PULSE;
      PON_HELD:
        if (is_pon)
          next_pon_state = PON_RUN;
      PON_PULSE:
        if (cmd.chip_rst)
          next_pon_state = PON_HELD;
        else if (is_pon)
          next_pon_state = PON_RUN;
        else
          next_pon_state = PON_RUN;
      default:
        next_pon_state = PON_HELD;
    endcase
  end

  // external reset leaves the message held, same as a chip reset
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      pon_state <= PON_HELD;
      PON_OUT   <= 1'b1;
    end
    else
    begin
      pon_state <= next_pon_state;
      PON_OUT   <= (next_pon_state != PON_RUN);
    end
  end

  // one pulse to the core clears poll mode, end bit, sysctl, request and mode bits
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      CHIP_RST_OUT <= 1'b0;
    else
      CHIP_RST_OUT <= cmd.chip_rst;
  end

  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      PP_FLAG_OUT <= 1'b0;
    else if (cmd.chip_rst)
      PP_FLAG_OUT <= 1'b0;
    else if (cmd.exec && cmd.code == `ACD_CMD_SET_PP)
      PP_FLAG_OUT <= 1'b1;
    else if (cmd.exec && cmd.code == `ACD_CMD_CLR_PP)
      PP_FLAG_OUT <= 1'b0;
  end

  // stall follows a held secondary; with the stall low a new hold wins over a release in the same cycle
  logic sec_release;
  assign sec_release = cmd.exec &&
    (cmd.code == `ACD_CMD_VALID || cmd.code == `ACD_CMD_NONVALID);

  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      ACC_STALL_OUT <= 1'b0;
    else if (SEC_HELD_IN && !ACC_STALL_OUT)
      ACC_STALL_OUT <= 1'b1;
    else if (sec_release)
      ACC_STALL_OUT <= 1'b0;
  end

  // one-cycle command pulses toward the core
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      SEC_VALID_OUT   <= 1'b0;
      SEC_INVALID_OUT <= 1'b0;
      FINISH_HS_OUT   <= 1'b0;
      TAKE_ASYNC_OUT  <= 1'b0;
      STANDBY_OUT     <= 1'b0;
      LISTEN_OUT      <= 1'b0;
      UNLISTEN_OUT    <= 1'b0;
    end
    else
    begin
      SEC_VALID_OUT   <= cmd.exec && cmd.code == `ACD_CMD_VALID;
      SEC_INVALID_OUT <= cmd.exec && cmd.code == `ACD_CMD_NONVALID;
      FINISH_HS_OUT   <= cmd.exec && cmd.code == `ACD_CMD_FINISH_HS;
      TAKE_ASYNC_OUT  <= cmd.exec && cmd.code == `ACD_CMD_TCA;
      STANDBY_OUT     <= cmd.exec && cmd.code == `ACD_CMD_STANDBY;
      LISTEN_OUT      <= cmd.exec && cmd.code == `ACD_CMD_LISTEN;
      UNLISTEN_OUT    <= cmd.exec && cmd.code == `ACD_CMD_UNLISTEN;
    end
  end

  // requests that persist until standby or power-on idles them
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      TAKE_SYNC_OUT   <= 1'b0;
      TAKE_ON_END_OUT <= 1'b0;
    end
    else if (next_pon_state != PON_RUN || (cmd.exec && cmd.code == `ACD_CMD_STANDBY))
    begin
      TAKE_SYNC_OUT   <= 1'b0;
      TAKE_ON_END_OUT <= 1'b0;
    end
    else if (cmd.exec && cmd.code == `ACD_CMD_TCS)
      TAKE_SYNC_OUT   <= 1'b1;
    else if (cmd.exec && cmd.code == `ACD_CMD_TCS_END)
      TAKE_ON_END_OUT <= 1'b1;
  end

  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      LISTEN_CONT_OUT <= 1'b0;
    else if (next_pon_state != PON_RUN)
      LISTEN_CONT_OUT <= 1'b0;
    else if (cmd.exec && cmd.code == `ACD_CMD_UNLISTEN)
      LISTEN_CONT_OUT <= 1'b0;
    else if (cmd.exec && cmd.code == `ACD_CMD_LSN_CONT)
      LISTEN_CONT_OUT <= 1'b1;
  end

  // checks
  logic known_code;
  assign known_code = cmd.code inside {`ACD_CMD_PON, `ACD_CMD_CLR_PP, `ACD_CMD_CHIP_RST,
    `ACD_CMD_FINISH_HS, `ACD_CMD_NONVALID, `ACD_CMD_SET_PP, `ACD_CMD_VALID,
    `ACD_CMD_STANDBY, `ACD_CMD_TCA, `ACD_CMD_TCS, `ACD_CMD_LISTEN,
    `ACD_CMD_TCS_END, `ACD_CMD_LSN_CONT, `ACD_CMD_UNLISTEN};

  logic is_fh;
  assign is_fh = cmd.exec && cmd.code == `ACD_CMD_FINISH_HS;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_read_zero: assert property (BUS_RD_IN |=> BUS_RDATA_OUT == 8'h00)
    else $error("command port read returned data");
  a_chip_rst_hold: assert property (cmd.chip_rst |=> PON_OUT && CHIP_RST_OUT
    && COUNTER_OUT == `ACD_ICR_RST && AUX_A_OUT == 5'h00 && !PP_FLAG_OUT)
    else $error("chip reset did not set defaults");
  a_pon_release: assert property (pon_state == PON_HELD && is_pon |=> !PON_OUT)
    else $error("power-on while held did not drop");
  // a chip reset right behind the pulse legally keeps the message up
  a_pon_pulse: assert property (pon_state == PON_RUN && is_pon && !cmd.chip_rst
    |=> PON_OUT ##1 (!PON_OUT || $past(cmd.chip_rst)))
    else $error("power-on pulse wrong");
  a_held_idle: assert property (pon_state == PON_HELD && !is_pon |=> PON_OUT)
    else $error("power-on dropped without command");
  a_pp_set: assert property (cmd.exec && cmd.code == `ACD_CMD_SET_PP |=> PP_FLAG_OUT)
    else $error("poll flag not set");
  a_pp_clear: assert property (cmd.exec && cmd.code == `ACD_CMD_CLR_PP |=> !PP_FLAG_OUT)
    else $error("poll flag not cleared");
  a_stall_keep: assert property (ACC_STALL_OUT && !sec_release |=> ACC_STALL_OUT)
    else $error("stall released without valid or invalid");
  a_stall_set: assert property (SEC_HELD_IN && !ACC_STALL_OUT |=> ACC_STALL_OUT)
    else $error("stall not raised for held secondary");
  a_sec_pulse: assert property (cmd.exec && cmd.code == `ACD_CMD_VALID
    |=> SEC_VALID_OUT && !SEC_INVALID_OUT)
    else $error("valid secondary pulse wrong");
  a_sec_invalid: assert property (cmd.exec && cmd.code == `ACD_CMD_NONVALID
    |=> SEC_INVALID_OUT && !SEC_VALID_OUT)
    else $error("invalid secondary pulse wrong");
  // back to back finish commands legally keep the pulse up
  a_finish_pulse: assert property (is_fh |=> FINISH_HS_OUT
    ##1 (!FINISH_HS_OUT || $past(is_fh)))
    else $error("finish handshake pulse wrong");
  a_take_sync: assert property (cmd.exec && cmd.code == `ACD_CMD_TCS && !PON_OUT
    |=> TAKE_SYNC_OUT)
    else $error("take control sync not raised");
  a_take_async: assert property (cmd.exec && cmd.code == `ACD_CMD_TCA
    |=> TAKE_ASYNC_OUT)
    else $error("take control async not pulsed");
  a_standby_clear: assert property (cmd.exec && cmd.code == `ACD_CMD_STANDBY
    |=> STANDBY_OUT && !TAKE_SYNC_OUT && !TAKE_ON_END_OUT)
    else $error("standby did not drop take control");
  a_take_on_end: assert property (cmd.exec && cmd.code == `ACD_CMD_TCS_END && !PON_OUT
    |=> TAKE_ON_END_OUT)
    else $error("take control on end not raised");
  a_listen_pulse: assert property (cmd.exec && cmd.code == `ACD_CMD_LISTEN
    |=> LISTEN_OUT)
    else $error("listen pulse not raised");
  a_listen_cont: assert property (cmd.exec && cmd.code == `ACD_CMD_LSN_CONT && !PON_OUT
    |=> LISTEN_CONT_OUT)
    else $error("continuous listen not raised");
  a_unlisten_clear: assert property (cmd.exec && cmd.code == `ACD_CMD_UNLISTEN
    |=> UNLISTEN_OUT && !LISTEN_CONT_OUT)
    else $error("unlisten did not drop listen");
  a_held_no_take: assert property (PON_OUT |-> !TAKE_SYNC_OUT && !TAKE_ON_END_OUT
    && !LISTEN_CONT_OUT)
    else $error("request level up while functions idle");
  // the pon pulse state drops the message by itself, so quiet checks skip it
  a_unknown_none: assert property (cmd.exec && !known_code && !SEC_HELD_IN
    && pon_state != PON_PULSE |=> $stable(PP_FLAG_OUT) && $stable(PON_OUT)
    && $stable(ACC_STALL_OUT) && $stable(TAKE_SYNC_OUT) && $stable(LISTEN_CONT_OUT)
    && !CHIP_RST_OUT)
    else $error("unimplemented code changed state");
  a_load_quiet: assert property (cmd.load && pon_state != PON_PULSE
    |=> !CHIP_RST_OUT && !FINISH_HS_OUT && $stable(PP_FLAG_OUT) && $stable(PON_OUT))
    else $error("hidden load triggered an action");
  a_hidden_load: assert property (cmd.load && cmd.ctl == `ACD_CTL_AUXA
    |=> AUX_A_OUT == $past(cmd.data))
    else $error("hidden register not loaded");

  c_chip_rst_then_pon: cover property (cmd.chip_rst ##[1:20] is_pon);
  c_hidden_load: cover property (cmd.load && cmd.ctl == `ACD_CTL_AUXB);
  c_stall_valid: cover property (ACC_STALL_OUT ##[1:10] sec_release);
  c_pon_pulse: cover property (pon_state == PON_RUN && is_pon);
  c_sync_standby: cover property (TAKE_SYNC_OUT ##[1:20] cmd.exec && cmd.code == `ACD_CMD_STANDBY);
endmodule

/* File: shared/acd_cmd_if.sv */
// decoded port write carried from the decoder to the top and hidden bank
`timescale 1ns/1ps
interface acd_cmd_if;
  import acd_pkg::*;
  logic       exec;
  acd_field_t code;
  logic       load;
  acd_ctl_t   ctl;
  acd_field_t data;
  logic       chip_rst;
  modport dec (output exec, output code, output load, output ctl, output data, output chip_rst);
  modport use_side (input exec, input code, input load, input ctl, input data, input chip_rst);
endinterface

/* File: shared/acd_map.svh */
// offsets, field positions, codes and reset values of the aux command port
`ifndef ACD_MAP_SVH
`define ACD_MAP_SVH
`define ACD_PORT_OFFSET   9'h11B
`define ACD_CTL_MSB       7
`define ACD_CTL_LSB       5
`define ACD_COM_MSB       4
`define ACD_COM_LSB       0
`define ACD_CTL_EXEC      3'h0
`define ACD_CTL_ICR       3'h1
`define ACD_CTL_PPR       3'h3
`define ACD_CTL_AUXA      3'h4
`define ACD_CTL_AUXB      3'h5
`define ACD_CTL_AUXE      3'h6
`define ACD_CMD_PON       5'h00
`define ACD_CMD_CLR_PP    5'h01
`define ACD_CMD_CHIP_RST  5'h02
`define ACD_CMD_FINISH_HS 5'h03
`define ACD_CMD_NONVALID  5'h07
`define ACD_CMD_SET_PP    5'h09
`define ACD_CMD_VALID     5'h0F
`define ACD_CMD_STANDBY   5'h10
`define ACD_CMD_TCA       5'h11
`define ACD_CMD_TCS       5'h12
`define ACD_CMD_LISTEN    5'h13
`define ACD_CMD_TCS_END   5'h1A
`define ACD_CMD_LSN_CONT  5'h1B
`define ACD_CMD_UNLISTEN  5'h1C
`define ACD_HID_RST       5'h00
`define ACD_ICR_RST       5'h08
`define ACD_NUM_HIDDEN    5
`endif

/* File: shared/acd_pkg.sv */
// types shared by the aux command decoder modules
package acd_pkg;
  typedef logic [4:0] acd_field_t;
  typedef logic [2:0] acd_ctl_t;
  typedef enum logic [1:0] {PON_RUN, PON_HELD, PON_PULSE} acd_pon_state_t;
endpackage

/* File: sim/acd_host.sv */
// host processor model driving the aux command port over the board bus
`timescale 1ns/1ps
`include "acd_map.svh"
module acd_host
(
  input  wire logic       clk_in,
  output logic      [8:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  initial
  begin
    addr_out  = 9'h000;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // one bus cycle; released lines show the inverse so stale data never matches
  task automatic xfer(input logic [8:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_in);
    #1;
    addr_out  = a;
    wdata_out = d;
    wr_out    = w;
    rd_out    = ~w;
    @(posedge clk_in);
    #1;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    addr_out  = ~a;
    wdata_out = ~d;
  endtask

  task automatic cmd(input logic [4:0] c);
    xfer(`ACD_PORT_OFFSET, {3'h0, c}, 1'b1);
  endtask
endmodule

/* File: sim/aux_command_decoder_bench.sv */
// self-checking bench for the aux command port
`timescale 1ns/1ps
`include "acd_map.svh"
module aux_command_decoder_bench;
  logic        clk;
  logic        rst;
  logic        sec_held;
  wire  [8:0]  addr;
  wire  [7:0]  wdata;
  wire         wr;
  wire         rd;
  wire  [7:0]  rdata;
  wire  [13:0] flags;
  wire  [24:0] hid;
  int          num_errors;
  int          n_checks;

  acd_host acd_host_inst (.clk_in(clk), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));

  acd_top acd_top_inst (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst), .BUS_ADDR_IN(addr), .BUS_WDATA_IN(wdata),
    .BUS_WR_IN(wr), .BUS_RD_IN(rd), .SEC_HELD_IN(sec_held), .BUS_RDATA_OUT(rdata),
    .PON_OUT(flags[13]), .CHIP_RST_OUT(flags[12]), .ACC_STALL_OUT(flags[11]),
    .SEC_VALID_OUT(flags[10]), .SEC_INVALID_OUT(flags[9]), .FINISH_HS_OUT(flags[8]),
    .PP_FLAG_OUT(flags[7]), .TAKE_ASYNC_OUT(flags[6]), .TAKE_SYNC_OUT(flags[5]),
    .TAKE_ON_END_OUT(flags[4]), .STANDBY_OUT(flags[3]), .LISTEN_OUT(flags[2]),
    .LISTEN_CONT_OUT(flags[1]), .UNLISTEN_OUT(flags[0]), .AUX_A_OUT(hid[24:20]),
    .AUX_B_OUT(hid[19:15]), .POLL_RESP_OUT(hid[14:10]), .AUX_E_OUT(hid[9:5]),
    .COUNTER_OUT(hid[4:0]));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic pw(input logic [7:0] d);
    acd_host_inst.xfer(`ACD_PORT_OFFSET, d, 1'b1);
  endtask

  task automatic t_reset;
    chk(flags, 14'h2000);
    chk(hid, 25'h8);
    acd_host_inst.xfer(`ACD_PORT_OFFSET, 8'h00, 1'b0);
    chk(rdata, 8'h00);
  endtask

  task automatic t_pon;
    acd_host_inst.cmd(5'h00);
    chk(flags, 14'h0000);
    acd_host_inst.cmd(5'h00);
    chk(flags, 14'h2000);
    @(posedge clk);
    #1;
    chk(flags, 14'h0000);
  endtask

  task automatic t_addr;
    acd_host_inst.xfer(9'h119, 8'h09, 1'b1);
    chk(flags, 14'h0000);
  endtask

  task automatic t_pp;
    acd_host_inst.cmd(5'h09);
    chk(flags, 14'h0080);
    acd_host_inst.cmd(5'h01);
    chk(flags, 14'h0000);
  endtask

  // command bits of 0x73 and 0xD1 are listen and take-control codes
  task automatic t_load;
    logic [7:0] b [7] = '{8'h8A, 8'hB5, 8'h73, 8'hD1, 8'h2C, 8'h5F, 8'hFF};
    foreach (b[i])
    begin
      pw(b[i]);
      chk(flags, 14'h0000);
    end
    chk(hid, {5'h0A, 5'h15, 5'h13, 5'h11, 5'h0C});
  endtask

  task automatic t_cmds;
    logic [4:0]  c [8] = '{5'h12, 5'h1A, 5'h1B, 5'h11, 5'h13, 5'h03, 5'h10, 5'h1C};
    logic [13:0] e [8] = '{14'h0020, 14'h0030, 14'h0032, 14'h0072,
                           14'h0036, 14'h0132, 14'h000A, 14'h0001};
    foreach (c[i])
    begin
      acd_host_inst.cmd(c[i]);
      chk(flags, e[i]);
    end
  endtask

  task automatic t_nop;
    logic [4:0] c [5] = '{5'h04, 5'h06, 5'h08, 5'h0E, 5'h1E};
    foreach (c[i])
    begin
      acd_host_inst.cmd(c[i]);
      chk(flags, 14'h0000);
    end
    chk(hid, {5'h0A, 5'h15, 5'h13, 5'h11, 5'h0C});
  endtask

  task automatic t_sec;
    logic [4:0]  c [2] = '{5'h0F, 5'h07};
    logic [13:0] e [2] = '{14'h0400, 14'h0200};
    int          k;
    foreach (c[i])
    begin
      sec_held = 1'b1;
      k = 0;
      while (flags[11] !== 1'b1 && k < 4)
      begin
        @(posedge clk);
        #1;
        k++;
      end
      if (flags[11] !== 1'b1)
      begin
        num_errors++;
        tally_and_finish;
      end
      sec_held = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(flags, 14'h0800);
      acd_host_inst.cmd(c[i]);
      chk(flags, e[i]);
    end
  endtask

  // poll response survives chip reset by design choice
  task automatic t_chip;
    acd_host_inst.cmd(5'h09);
    acd_host_inst.cmd(5'h12);
    acd_host_inst.cmd(5'h1B);
    acd_host_inst.cmd(5'h02);
    chk(flags, 14'h3000);
    chk(hid, {5'h00, 5'h00, 5'h13, 5'h00, 5'h08});
    @(posedge clk);
    #1;
    chk(flags, 14'h2000);
    pw(8'hB5);
    chk(hid, {5'h00, 5'h15, 5'h13, 5'h00, 5'h08});
    chk(flags, 14'h2000);
    acd_host_inst.cmd(5'h12);
    chk(flags, 14'h2000);
    acd_host_inst.cmd(5'h00);
    chk(flags, 14'h0000);
  endtask

  initial
  begin
    num_errors = 0;
    n_checks   = 0;
    rst        = 1'b1;
    sec_held   = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_pon;
    t_addr;
    t_pp;
    t_load;
    t_cmds;
    t_nop;
    t_sec;
    t_chip;
    tally_and_finish;
  end
endmodule
